// ### logic/lcdstc_top.sv
// Purpose: segment LCD timing controller with APB registers
// Assumes: oscillator ticks and sleep request synchronous to pclk
// Notes: bias voltages are external; outputs give logical drive levels
// Overview of operation
// - Three sources: RC, low-speed, system/256
// - RC oscillator off unless selected and enabled
// - System divider fixed; prescaler sets frame rate
// - Source select in control bits 3:2
// - One to four commons from mode bits
// - Frame = source/(128*(prescale+1)) most modes
// - Third mode frame = source/(96*(prescale+1))
// - Frame starts at first common leading edge
// - Frame flag set after frame data read
// - Next frame read starts within write window
// - Pixel bit one dark, zero clear
// - Unused pixel bits are plain storage
// - Control bit 6 selects halt in sleep
// - Halting sleep drives minimum voltage everywhere
// - Running sleep shows frozen pixel data
// - Sleep operation only from RC or low-speed
// - Segment select bit makes pin group LCD
// - Set select overrides port direction
// - Reset brings all groups up as LCD
// - Mux mode owns the extra common pins
// - Source code 00 sys, 01 low-speed, 1x RC
// - Mode code 00 static up to 11 quarter
// - Control bit 7 enables drive
`timescale 1ns/1ps
module lcdstc_top
  import lcdstc_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic sleep_req, // Core in sleep
  input wire logic rc_tick, // RC oscillator tick
  input wire logic lso_tick, // Low-speed oscillator tick
  output logic rc_osc_on, // RC oscillator power request
  output logic vgen_on, // Bias generator enable
  output logic low_current, // Low-current mode
  output lcdstc_pkg::lcdstc_drive_t drive, // Common and segment drive
  output logic [7:0] group_lcd, // Pin group in LCD use
  output logic [7:0] group_oe_n, // Digital output enable, low drives
  output logic [2:0] xcom_lcd // Extra common pins in LCD use
);
  localparam int unsigned PB = LCDSTC_PIXEL_BYTES;
  lcdstc_cfg_t cfg_reg;
  logic [3:0] presc_reg;
  logic [7:0] segsel_reg;
  logic [7:0] portdir_reg;
  logic frame_flag_reg;
  logic [7:0] pixel_mem [PB];
  logic [31:0] prdata_reg;
  logic [1:0] com_index;
  logic frame_start;
  logic fetch_done;
  logic src_tick;
  logic halted;
  logic run;
  logic wr_en;
  logic rd_en;
  logic hit_pix;
  logic [3:0] pix_idx;
  logic [31:0] seg_latch_reg;
  logic [3:0] com_on_reg;
  logic [1:0] com_idx_reg;
  logic [1:0] com_next;
  logic [31:0] row_next;
  logic [7:0] rd_byte;
  logic sel_ctl;
  logic sel_pre;
  logic sel_seg;
  logic sel_dir;
  logic sel_sta;
  logic mapped;
  logic ctl_wr;
  logic pre_wr;
  logic sta_wr;
  logic pix_wr;

  function automatic logic [7:0] lcdstc_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                              input logic en);
    return en ? new_v : old_v;
  endfunction

  // Pixel store bit that holds segment seg on common com
  function automatic int lcdstc_bit_index(input int seg, input logic [1:0] com);
    return seg * int'(lcdstc_commons(LCDSTC_MUX_QUARTER)) + int'(com);
  endfunction

  // Zero wait states; unmapped addresses answer with error
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && !sleep_req;
  assign rd_en = psel && !penable && !pwrite;
  assign hit_pix = (paddr >= LCDSTC_OFS_PIXEL_BASE) && (paddr < LCDSTC_OFS_PIXEL_BASE + 12'(PB * 4))
                   && (paddr[1:0] == 2'b00);
  assign pix_idx = 4'((paddr - LCDSTC_OFS_PIXEL_BASE) >> 2);

  // One decode shared by the error, write and read paths
  always_comb
  begin
    sel_ctl = (paddr == LCDSTC_OFS_PANEL_CONTROL);
    sel_pre = (paddr == LCDSTC_OFS_FRAME_RATE);
    sel_seg = (paddr == LCDSTC_OFS_SEG_SELECT);
    sel_dir = (paddr == LCDSTC_OFS_PORT_DIR);
    sel_sta = (paddr == LCDSTC_OFS_STATUS);
    mapped = hit_pix || sel_ctl || sel_pre || sel_seg || sel_dir || sel_sta;
  end

  // Registers are one byte wide, so only byte lane 0 writes them
  always_comb
  begin
    ctl_wr = wr_en && pstrb[0] && sel_ctl;
    pre_wr = wr_en && pstrb[0] && sel_pre;
    sta_wr = wr_en && pstrb[0] && sel_sta;
    pix_wr = wr_en && pstrb[0] && hit_pix;
  end

  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      pslverr = !mapped;
    end
  end

  // Control register: fields at 7, 6, 4, 3:2, 1:0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_reg <= lcdstc_cfg_t'(7'h00);
    else if (ctl_wr)
    begin
      cfg_reg.drive_on <= pwdata[LCDSTC_BIT_DRIVE_ON];
      cfg_reg.halt_in_sleep <= pwdata[LCDSTC_BIT_HALT_SLEEP];
      cfg_reg.vgen_on <= pwdata[LCDSTC_BIT_VGEN];
      cfg_reg.clk_src_sel <= lcdstc_clk_src_t'(pwdata[LCDSTC_CS_HI:LCDSTC_CS_LO]);
      cfg_reg.mux_mode_sel <= lcdstc_mux_t'(pwdata[LCDSTC_MUX_HI:LCDSTC_MUX_LO]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_reg <= LCDSTC_PRESC_RST[3:0];
    else if (pre_wr)
      presc_reg <= pwdata[3:0];
  end

  // All groups come up as LCD drivers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      segsel_reg <= LCDSTC_SEGSEL_RST;
      portdir_reg <= LCDSTC_PORTDIR_RST;
    end
    else
    begin
      if (wr_en && sel_seg)
        segsel_reg <= lcdstc_merge(segsel_reg, pwdata[7:0], pstrb[0]);
      if (wr_en && sel_dir)
        portdir_reg <= lcdstc_merge(portdir_reg, pwdata[7:0], pstrb[0]);
    end
  end

  // Pixel store; writes blocked during sleep unused bits kept as RAM
  always_ff @(posedge pclk)
  begin
    if (pix_wr)
      pixel_mem[pix_idx] <= pwdata[7:0];
  end

  // Sticky flag; a new frame event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_flag_reg <= 1'b0;
    else if (fetch_done)
      frame_flag_reg <= 1'b1;
    else if (sta_wr && pwdata[0])
      frame_flag_reg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (rd_en)
      prdata_reg <= {24'h00_0000, rd_byte};
  end
  assign prdata = prdata_reg;

  // Read byte chosen here, registered at the setup cycle
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_pix)
    begin
      rd_byte = pixel_mem[pix_idx];
    end
    else if (sel_ctl)
    begin
      rd_byte = {cfg_reg[6:5], 1'b0, cfg_reg[4:0]} & LCDSTC_PANEL_MASK;
    end
    else if (sel_pre)
    begin
      rd_byte = {4'h0, presc_reg};
    end
    else if (sel_seg)
    begin
      rd_byte = segsel_reg;
    end
    else if (sel_dir)
    begin
      rd_byte = portdir_reg;
    end
    else if (sel_sta)
    begin
      rd_byte = {5'h00, rc_osc_on, run, frame_flag_reg};
    end
  end

  // Halt when sleep is set to stop or the system clock was the source
  assign halted = sleep_req && (cfg_reg.halt_in_sleep || cfg_reg.clk_src_sel == LCDSTC_CS_SYS);
  assign run = cfg_reg.drive_on && !halted;
  assign low_current = halted;
  assign vgen_on = cfg_reg.vgen_on && run;

  lcdstc_clk_sel u_clk_sel (
    .pclk(pclk),
    .presetn(presetn),
    .clk_src_sel(cfg_reg.clk_src_sel),
    .drive_on(cfg_reg.drive_on),
    .sleeping(sleep_req),
    .rc_tick(rc_tick),
    .lso_tick(lso_tick),
    .rc_osc_on(rc_osc_on),
    .src_tick(src_tick)
  );

  lcdstc_frame_gen u_frame_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .src_tick(src_tick),
    .mux_mode_sel(cfg_reg.mux_mode_sel),
    .frame_prescale(presc_reg),
    .com_index(com_index),
    .frame_start(frame_start),
    .fetch_done(fetch_done)
  );

  // Row and common change on the same tick, so a frame never opens
  // with the last common's segments
  assign com_next = frame_start ? 2'b00 : com_index;

  // Segment bits for the common about to be shown
  always_comb
  begin
    row_next = 32'h0000_0000;
    for (int s = 0; s < 32; s++)
    begin
      row_next[s] = pixel_mem[lcdstc_bit_index(s, com_next) / 8][lcdstc_bit_index(s, com_next) % 8];
    end
  end

  // Fetch of the next frame begins on the tick after the flag,
  // inside the write window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seg_latch_reg <= 32'h0000_0000;
    else if (!run)
      seg_latch_reg <= 32'h0000_0000;
    else if (src_tick)
      seg_latch_reg <= row_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      com_idx_reg <= 2'b00;
    else if (!run)
      com_idx_reg <= 2'b00;
    else if (src_tick)
      com_idx_reg <= com_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      com_on_reg <= 4'h0;
    else if (!run)
      com_on_reg <= 4'h0;
    else if (src_tick)
    begin
      for (int c = 0; c < 4; c++)
        com_on_reg[c] <= (c < int'(lcdstc_commons(cfg_reg.mux_mode_sel)));
    end
  end

  // Lines fall to the minimum level the moment the module halts
  always_comb
  begin
    drive.common_active = com_on_reg;
    drive.segment_level = 32'h0000_0000;
    drive.common_level = 4'h0;
    if (run)
    begin
      drive.segment_level = seg_latch_reg;
      drive.common_level[com_idx_reg] = 1'b1;
    end
  end

  // Select bit gives group to LCD and overrides direction
  assign group_lcd = segsel_reg;
  assign group_oe_n = segsel_reg | portdir_reg;
  // Extra commons follow the mode, not the select bits
  always_comb
  begin
    unique case (cfg_reg.mux_mode_sel)
      LCDSTC_MUX_STATIC:
      begin
        xcom_lcd = 3'h0;
      end
      LCDSTC_MUX_HALF:
      begin
        xcom_lcd = 3'h1;
      end
      LCDSTC_MUX_THIRD:
      begin
        xcom_lcd = 3'h3;
      end
      LCDSTC_MUX_QUARTER:
      begin
        xcom_lcd = 3'h7;
      end
    endcase
  end
endmodule

// ### common/lcdstc_pkg.sv
// Purpose: shared constants and types for the segment LCD timing controller
// Assumes: APB with 32-bit data, one byte address per register
// Notes: register offsets are byte addresses
package lcdstc_pkg;
  localparam int unsigned LCDSTC_CLK_HZ = 25000000;
  // Register offsets (byte addresses)
  localparam logic [11:0] LCDSTC_OFS_PANEL_CONTROL = 12'h10F;
  localparam logic [11:0] LCDSTC_OFS_FRAME_RATE = 12'h10E;
  localparam logic [11:0] LCDSTC_OFS_SEG_SELECT = 12'h10D;
  localparam logic [11:0] LCDSTC_OFS_STATUS = 12'h100;
  localparam logic [11:0] LCDSTC_OFS_PORT_DIR = 12'h104;
  localparam logic [11:0] LCDSTC_OFS_PIXEL_BASE = 12'h110;
  localparam int unsigned LCDSTC_PIXEL_BYTES = 16;
  // Panel control field positions
  localparam int unsigned LCDSTC_BIT_DRIVE_ON = 7;
  localparam int unsigned LCDSTC_BIT_HALT_SLEEP = 6;
  localparam int unsigned LCDSTC_BIT_VGEN = 4;
  localparam int unsigned LCDSTC_CS_HI = 3;
  localparam int unsigned LCDSTC_CS_LO = 2;
  localparam int unsigned LCDSTC_MUX_HI = 1;
  localparam int unsigned LCDSTC_MUX_LO = 0;
  localparam logic [7:0] LCDSTC_PANEL_MASK = 8'hDF;
  // Reset values
  localparam logic [7:0] LCDSTC_PANEL_RST = 8'h00;
  localparam logic [7:0] LCDSTC_PRESC_RST = 8'h00;
  localparam logic [7:0] LCDSTC_SEGSEL_RST = 8'hFF;
  localparam logic [7:0] LCDSTC_PORTDIR_RST = 8'hFF;
  // Clocking constants
  localparam int unsigned LCDSTC_SYS_DIV = 256;
  localparam int unsigned LCDSTC_BASE_DIV_STD = 128;
  localparam int unsigned LCDSTC_BASE_DIV_THIRD = 96;
  // Last common slot ends a frame; flag is raised this many ticks before
  localparam int unsigned LCDSTC_FETCH_LEAD = 1;

  typedef enum logic [1:0] {
    LCDSTC_CS_SYS = 2'b00,
    LCDSTC_CS_LSO = 2'b01,
    LCDSTC_CS_RC = 2'b10,
    LCDSTC_CS_RC2 = 2'b11
  } lcdstc_clk_src_t;

  typedef enum logic [1:0] {
    LCDSTC_MUX_STATIC = 2'b00,
    LCDSTC_MUX_HALF = 2'b01,
    LCDSTC_MUX_THIRD = 2'b10,
    LCDSTC_MUX_QUARTER = 2'b11
  } lcdstc_mux_t;

  typedef struct packed {
    logic drive_on;
    logic halt_in_sleep;
    logic vgen_on;
    lcdstc_clk_src_t clk_src_sel;
    lcdstc_mux_t mux_mode_sel;
  } lcdstc_cfg_t;

  typedef struct packed {
    logic [3:0] common_level;
    logic [31:0] segment_level;
    logic [3:0] common_active;
  } lcdstc_drive_t;

  function automatic int unsigned lcdstc_commons(input lcdstc_mux_t m);
    return int'(m) + 1;
  endfunction
endpackage

// ### logic/lcdstc_clk_sel.sv
// Purpose: picks and divides the LCD tick source
// Assumes: RC and low-speed oscillator ticks arrive as pclk-synchronous pulses
// Notes: system clock branch is a fixed divide by 256
`timescale 1ns/1ps
module lcdstc_clk_sel
  import lcdstc_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire lcdstc_pkg::lcdstc_clk_src_t clk_src_sel, // Source select
  input wire logic drive_on, // Module enabled
  input wire logic sleeping, // Core asleep
  input wire logic rc_tick, // Internal RC oscillator tick
  input wire logic lso_tick, // Low-speed oscillator tick
  output logic rc_osc_on, // Power request to RC oscillator
  output logic src_tick // Selected source tick
);
  localparam int unsigned DIV_W = $clog2(LCDSTC_SYS_DIV);
  logic [DIV_W-1:0] sys_div_reg;
  logic sys_tick;

  // Fixed ratio; frame rate only through the prescaler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys_div_reg <= '0;
    else if (!sleeping)
      sys_div_reg <= sys_div_reg + 1'b1;
  end

  // Stops in sleep with the system clock
  assign sys_tick = !sleeping && (sys_div_reg == DIV_W'(LCDSTC_SYS_DIV - 1));

  // RC runs only when chosen and enabled
  assign rc_osc_on = drive_on && clk_src_sel[1];

  // Three sources encoding 00/01/1x
  always_comb
  begin
    unique case (clk_src_sel)
      LCDSTC_CS_SYS: src_tick = sys_tick;
      LCDSTC_CS_LSO: src_tick = lso_tick;
      default: src_tick = rc_tick & rc_osc_on;
    endcase
  end
endmodule

// ### logic/lcdstc_frame_gen.sv
// Purpose: prescaler and common slot sequencer
// Assumes: src_tick is one pclk wide
// Notes: frame length = base * (prescale + 1) ticks
`timescale 1ns/1ps
module lcdstc_frame_gen
  import lcdstc_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic run, // Counting allowed
  input wire logic src_tick, // Source tick
  input wire lcdstc_pkg::lcdstc_mux_t mux_mode_sel, // Multiplex mode
  input wire logic [3:0] frame_prescale, // Prescale value
  output logic [1:0] com_index, // Active common
  output logic frame_start, // Pulse at first common leading edge
  output logic fetch_done // Pulse when frame data is fully read
);
  localparam int unsigned CW = 12;
  logic [CW-1:0] tick_cnt_reg;
  logic [CW-1:0] frame_len;
  logic [CW-1:0] slot_len;
  logic [CW-1:0] slot_cnt_reg;
  logic [1:0] com_reg;

  // 96 base in 1/3 mode 128 otherwise
  always_comb
  begin
    if (mux_mode_sel == LCDSTC_MUX_THIRD)
      frame_len = CW'(LCDSTC_BASE_DIV_THIRD * (frame_prescale + 1));
    else
      frame_len = CW'(LCDSTC_BASE_DIV_STD * (frame_prescale + 1));
    slot_len = CW'(frame_len / CW'(lcdstc_commons(mux_mode_sel)));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_reg <= '0;
      slot_cnt_reg <= '0;
      com_reg <= '0;
    end
    else if (!run)
    begin
      tick_cnt_reg <= '0;
      slot_cnt_reg <= '0;
      com_reg <= '0;
    end
    else if (src_tick)
    begin
      if (tick_cnt_reg >= frame_len - 1'b1)
      begin
        tick_cnt_reg <= '0;
        slot_cnt_reg <= '0;
        com_reg <= '0;
      end
      else
      begin
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
        if (slot_cnt_reg >= slot_len - 1'b1)
        begin
          slot_cnt_reg <= '0;
          com_reg <= com_reg + 1'b1;
        end
        else
          slot_cnt_reg <= slot_cnt_reg + 1'b1;
      end
    end
  end

  assign com_index = com_reg;
  // Frame begins at first common leading edge
  assign frame_start = run && src_tick && (tick_cnt_reg >= frame_len - 1'b1);
  // Data read ends a fixed lead before the boundary
  assign fetch_done = run && src_tick && (tick_cnt_reg == frame_len - 1'b1 - CW'(LCDSTC_FETCH_LEAD));
endmodule

// ### verification/lcdstc_top_assertions.sv
// Purpose: port-level checks for the LCD timing controller
// Assumes: single pclk domain, async active-low reset
// Notes: bound to lcdstc_top at the foot of this file
`timescale 1ns/1ps
module lcdstc_top_assertions
  import lcdstc_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [11:0] paddr, // APB byte address
  input wire logic pslverr, // APB error
  input wire logic sleep_req, // Core in sleep
  input wire logic low_current, // Low-current mode
  input wire lcdstc_pkg::lcdstc_drive_t drive, // Line drive
  input wire logic [7:0] group_lcd, // Pin groups in LCD use
  input wire logic [7:0] group_oe_n, // Digital output enable
  input wire logic [2:0] xcom_lcd // Extra commons in LCD use
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic pix_addr;
  assign pix_addr = (paddr >= LCDSTC_OFS_PIXEL_BASE) && (paddr <= 12'h14C) && (paddr[1:0] == 2'h0);
  a_halt_min_volt: assert property (low_current |-> drive.common_level == 4'h0 && drive.segment_level == 32'h0)
    else $error("halted module still drives lines");
  a_halt_only_sleep: assert property (low_current |-> sleep_req)
    else $error("low current outside sleep");
  a_wake_release: assert property ($fell(sleep_req) |-> ##[0:2] !low_current)
    else $error("low current held after wake");
  a_select_override: assert property ((group_lcd & ~group_oe_n) == 8'h00)
    else $error("LCD group driven as digital output");
  a_single_common: assert property ($onehot0(drive.common_level))
    else $error("more than one common active");
  a_xcom_codes: assert property (xcom_lcd inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("extra common pins not a mode pattern");
  a_reset_lcd_pins: assert property ($rose(presetn) |-> group_lcd == 8'hFF)
    else $error("pin groups not LCD after reset");
  a_pixel_no_err: assert property (psel && penable && pix_addr |-> !pslverr)
    else $error("pixel byte access refused");
  c_halt: cover property (low_current);
  c_quarter: cover property (drive.common_level[3]);
  c_refused: cover property (pslverr);
endmodule

bind lcdstc_top lcdstc_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr, .sleep_req,
  .low_current, .drive, .group_lcd, .group_oe_n, .xcom_lcd);

// ### verification/lcdstc_panel.sv
// Purpose: behavioural segment panel on the common and segment lines
// Assumes: drive levels are pclk synchronous
// Notes: marks frame starts only; no analog model
`timescale 1ns/1ps
module lcdstc_panel
  import lcdstc_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire lcdstc_pkg::lcdstc_drive_t drive, // Lines from controller
  output logic frame_pulse // One cycle after a frame begins
);
  logic first_common_line_last;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_common_line_last <= 1'b0;
      frame_pulse <= 1'b0;
    end
    else
    begin
      first_common_line_last <= drive.common_level[0];
      frame_pulse <= drive.common_level[0] & ~first_common_line_last;
    end
  end
endmodule

// ### verification/lcdstc_top_test.sv
// Purpose: self-checking bench for the LCD timing controller
// Assumes: oscillator ticks made here, synchronous to pclk
// Notes: low-speed tick every 2 cycles, RC tick every 3
`timescale 1ns/1ps
module lcdstc_top_test;
  import lcdstc_pkg::*;
  localparam logic [11:0] CTL = LCDSTC_OFS_PANEL_CONTROL;
  localparam logic [11:0] PRE = LCDSTC_OFS_FRAME_RATE;
  localparam logic [11:0] STA = LCDSTC_OFS_STATUS;
  localparam logic [11:0] PIX = LCDSTC_OFS_PIXEL_BASE;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req, rc_tick, lso_tick;
  logic rc_osc_on, vgen_on, low_current, frame_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [3:0] pstrb;
  logic [7:0] group_lcd, group_oe_n;
  logic [2:0] xcom_lcd;
  logic [1:0] rc_cnt;
  lcdstc_drive_t drive;
  int miscompares = 0;
  int cmp_count = 0;
  lcdstc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .sleep_req, .rc_tick, .lso_tick, .rc_osc_on, .vgen_on, .low_current, .drive, .group_lcd,
    .group_oe_n, .xcom_lcd);
  lcdstc_panel panel (.pclk, .presetn, .drive, .frame_pulse);
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    lso_tick <= ~lso_tick;
    rc_cnt <= (rc_cnt == 2'd2) ? 2'd0 : rc_cnt + 2'd1;
    rc_tick <= (rc_cnt == 2'd0);
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    chk("pslverr", 32'(e), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(name, exp, rd_data);
  endtask
  task automatic wait_frame();
    do @(posedge pclk); while (frame_pulse !== 1'b1);
  endtask
  task automatic t_reset();
    chk("group_lcd", 32'hFF, 32'(group_lcd));
    chk("xcom_lcd", 32'h0, 32'(xcom_lcd));
    rd("control", CTL, 32'h0);
    rd("prescale", PRE, 32'h0);
    rd("seg_select", LCDSTC_OFS_SEG_SELECT, 32'hFF);
    rd("port_dir", LCDSTC_OFS_PORT_DIR, 32'hFF);
    $display("test reset done");
  endtask
  task automatic t_regs();
    wr(CTL, 32'hFF);
    rd("control", CTL, 32'hDF);
    chk("vgen_on", 32'h1, 32'(vgen_on));
    chk("rc_on", 32'h1, 32'(rc_osc_on));
    for (int cs = 0; cs < 4; cs++)
    begin
      wr(CTL, 32'h80 | (cs << 2));
      chk("rc_on", 32'(cs >> 1), 32'(rc_osc_on));
    end
    wr(CTL, 32'h08);
    chk("vgen_on", 32'h0, 32'(vgen_on));
    chk("rc_on", 32'h0, 32'(rc_osc_on));
    wr(12'h14C, 32'hA5);
    rd("pixel15", 12'h14C, 32'hA5);
    wr(12'h130, 32'h5A);
    rd("pixel8", 12'h130, 32'h5A);
    apb(1'b0, 12'h008, 32'h0, 1'b1);
    $display("test registers done");
  endtask
  // Low-speed and RC sources need no setup beyond the drive enable bit 7
  task automatic t_frame(input logic [1:0] m, input logic [1:0] cs, input logic [3:0] p, input int exp);
    longint t0;
    wr(PRE, 32'(p));
    wr(CTL, 32'({4'h8, cs, m}));
    chk("xcom_lcd", 32'((4'd1 << m) - 4'd1), 32'(xcom_lcd));
    wait_frame();
    wait_frame();
    t0 = $time;
    wait_frame();
    chk("frame_cycles", 32'(exp), 32'(($time - t0) / 40));
    apb(1'b0, STA, 32'h0, 1'b0);
    chk("flag_set", 32'h1, 32'(rd_data[0]));
    wr(STA, 32'h1);
    apb(1'b0, STA, 32'h0, 1'b0);
    chk("flag_clear", 32'h0, 32'(rd_data[0]));
    wait_frame();
    apb(1'b0, STA, 32'h0, 1'b0);
    chk("flag_again", 32'h1, 32'(rd_data[0]));
    $display("test frame mode %0d done", m);
  endtask
  task automatic t_pixel(input logic [7:0] d, input logic [1:0] exp);
    wr(CTL, 32'h85);
    wr(PIX, 32'(d));
    wait_frame();
    wait_frame();
    chk("row_at_start", 32'(exp), 32'(drive.segment_level[1:0]));
    @(posedge pclk);
    chk("common", 32'h1, 32'(drive.common_level));
    chk("common_active", 32'h3, 32'(drive.common_active));
    chk("segments", 32'(exp), 32'(drive.segment_level[1:0]));
    $display("test pixel done");
  endtask
  task automatic t_sleep();
    wr(PRE, 32'h1);
    wr(CTL, 32'hC5);
    wait_frame();
    sleep_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("low_current", 32'h1, 32'(low_current));
    chk("halt_segments", 32'h0, drive.segment_level);
    wr(PRE, 32'h3);
    sleep_req <= 1'b0;
    rd("prescale_kept", PRE, 32'h1);
    wr(CTL, 32'h85);
    sleep_req <= 1'b1;
    wait_frame();
    chk("low_current", 32'h0, 32'(low_current));
    sleep_req <= 1'b0;
    wr(CTL, 32'h81);
    sleep_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("low_current", 32'h1, 32'(low_current));
    sleep_req <= 1'b0;
    $display("test sleep done");
  endtask
  task automatic t_pins();
    wr(LCDSTC_OFS_SEG_SELECT, 32'h0);
    wr(LCDSTC_OFS_PORT_DIR, 32'h0F);
    chk("group_lcd", 32'h0, 32'(group_lcd));
    chk("group_oe_n", 32'h0F, 32'(group_oe_n));
    wr(LCDSTC_OFS_SEG_SELECT, 32'hF0);
    chk("group_oe_n", 32'hFF, 32'(group_oe_n));
    $display("test pins done");
  endtask
  task automatic stop_test();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  initial
  begin
    {psel, penable, pwrite, sleep_req, rc_tick, lso_tick} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    rc_cnt = 2'd0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_frame(2'b11, 2'b01, 4'h1, 512);
    t_frame(2'b10, 2'b01, 4'h1, 384);
    t_frame(2'b01, 2'b10, 4'h0, 384);
    t_pixel(8'h01, 2'b01);
    t_pixel(8'h10, 2'b10);
    t_sleep();
    t_pins();
    stop_test();
  end
endmodule
